// ==== bench/aau_conv_model.sv ====
// Purpose: Converter core model in front of the accumulate unit.
// Assumes: One conversion at a time.
// Notes: Latency is a parameter so slow answers can be tried.
`timescale 1ns/1ns
module aau_conv_model #(
	parameter LAT = 3
) (
	// Clock and reset.
	input  wire       i_ref_clk,
	input  wire       i_rst_b,
	// Requests.
	input  wire       i_go,
	input  wire [9:0] i_value,
	input  wire       i_conv_trigger,
	// Results.
	output reg        o_conv_start,
	output reg        o_conv_done,
	output reg  [9:0] o_conv_result
);
	reg [3:0] left;
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			left <= 4'h0;
			o_conv_start <= 1'b0;
			o_conv_done <= 1'b0;
			o_conv_result <= 10'h000;
		end else begin
			o_conv_start <= i_go | i_conv_trigger;
			o_conv_done <= (left == 4'h1);
			// Result is only valid with done, so it toggles otherwise.
			o_conv_result <= (left == 4'h1) ? i_value : ~o_conv_result;
			if (i_go | i_conv_trigger)
				left <= LAT[3:0];
			else if (left != 4'h0)
				left <= left - 4'h1;
		end
	end
endmodule // aau_conv_model

// ==== bench/aau_monitor.sv ====
// Purpose: Port checks of the accumulate unit.
// Assumes: Bench keeps conversions away from clears and byte writes.
// Notes: Trigger check needs the comparator high for some clocks.
`timescale 1ns/1ns
`include "aau_defs.vh"
module aau_monitor (
	// Clock, reset and register port.
	input wire        i_ref_clk,
	input wire        i_rst_b,
	input wire [3:0]  i_addr,
	input wire [7:0]  i_wdata,
	input wire        i_wr,
	input wire        i_rd,
	input wire [7:0]  o_rdata,
	// Converter side.
	input wire        i_conv_start,
	input wire        i_conv_done,
	input wire [9:0]  i_conv_result,
	input wire        i_cmp_out,
	input wire        o_conv_trigger,
	input wire        o_thresh_check,
	input wire [15:0] o_thresh_value
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	sequence clr_req;
		i_wr && i_addr == `AAU_A_CTRL && i_wdata[`AAU_B_ACLR];
	endsequence
	sequence quiet7;
		(!i_conv_done && !i_wr)[*7];
	endsequence
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_unmapped_zero: assert property (i_rd && i_addr > `AAU_A_RESH |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_acc_bytes: assert property ((i_wr && i_addr == `AAU_A_ACCH && !i_conv_done) ##1
		!i_conv_done ##1 (i_rd && i_addr == `AAU_A_ACCH) |=> o_rdata == $past(i_wdata, 3))
		else $error("accumulator byte lost");
	a_clear_zero: assert property (clr_req ##1 quiet7 ##0 (i_rd && i_addr == `AAU_A_CNT)
		|=> o_rdata == 8'h00) else $error("counter not cleared");
	a_check_cause: assert property (o_thresh_check |-> $past(i_conv_done))
		else $error("check without conversion");
	a_value_hold: assert property (!o_thresh_check |-> $stable(o_thresh_value))
		else $error("threshold value moved");
	a_trig_cause: assert property (o_conv_trigger |-> $past(i_cmp_out, 2))
		else $error("trigger without comparator");
	a_trig_single: assert property (o_conv_trigger |=> !o_conv_trigger)
		else $error("trigger too long");
endmodule // aau_monitor
bind aau_core aau_monitor i_mon (.i_ref_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
	.o_rdata, .i_conv_start, .i_conv_done, .i_conv_result, .i_cmp_out, .o_conv_trigger,
	.o_thresh_check, .o_thresh_value);

// ==== bench/test_aau_core.sv ====
// Purpose: Self-checking bench of the accumulate unit.
// Assumes: Converter model answers after a fixed latency.
// Notes: Rows cover the modes; odd cases follow by hand.
`timescale 1ns/1ns
`include "aau_defs.vh"
module test_aau_core;
	reg         clk = 1'b0, rst_b = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, go = 1'b0, cmp = 1'b0;
	reg  [3:0]  addr = 4'h0;
	reg  [7:0]  wdata = 8'h00;
	reg  [9:0]  val = 10'h000;
	wire [7:0]  rdata;
	wire [9:0]  res;
	wire [15:0] thr;
	wire        start, done, trig, chk;
	integer     mismatches = 0, comparisons = 0, i, n;
	reg  [47:0] row [0:5];
	always #25 clk = ~clk;
	aau_core i_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
		.i_wr(bus_wr), .i_rd(bus_rd), .o_rdata(rdata), .i_conv_start(start),
		.i_conv_done(done), .i_conv_result(res), .i_cmp_out(cmp), .o_conv_trigger(trig),
		.o_thresh_check(chk), .o_thresh_value(thr));
	aau_conv_model i_conv (.i_ref_clk(clk), .i_rst_b(rst_b), .i_go(go), .i_value(val),
		.i_conv_trigger(trig), .o_conv_start(start), .o_conv_done(done), .o_conv_result(res));
	task give_verdict;
		begin
			$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
			if (mismatches == 0 && comparisons > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task cmp_val(input string what, input [15:0] exp, input [15:0] got);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("[ERR] %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task reg_write(input [3:0] a, input [7:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= d;
			bus_wr <= 1'b1;
			@(posedge clk);
			bus_wr <= 1'b0;
		end
	endtask
	task reg_read(input [3:0] a, input [7:0] exp);
		begin
			@(posedge clk);
			addr <= a;
			bus_rd <= 1'b1;
			@(posedge clk);
			bus_rd <= 1'b0;
			@(negedge clk);
			cmp_val("read data", {8'h00, exp}, {8'h00, rdata});
		end
	endtask
	// A conversion that never ends cuts the run short.
	task conv(input [9:0] v, input c);
		begin
			@(posedge clk);
			go <= 1'b1;
			val <= v;
			@(posedge clk);
			go <= 1'b0;
			for (n = 0; n < 20 && done !== 1'b1; n = n + 1)
				@(negedge clk);
			if (n == 20) begin
				mismatches = mismatches + 1;
				give_verdict;
			end
			@(negedge clk);
			cmp_val("check flag", {15'h0000, c}, {15'h0000, chk});
		end
	endtask
	initial begin
		row[0] = {3'h1, 3'h0, 10'h3FF, 8'hFE, 8'h02, 16'h07FE};
		row[1] = {3'h1, 3'h3, 10'h100, 8'h40, 8'h02, 16'h0200};
		row[2] = {3'h2, 3'h1, 10'h0F0, 8'hF0, 8'h02, 16'h00F0};
		row[3] = {3'h3, 3'h2, 10'h0C0, 8'h60, 8'h02, 16'h0060};
		row[4] = {3'h0, 3'h0, 10'h055, 8'h00, 8'h00, 16'h0055};
		row[5] = {3'h4, 3'h1, 10'h100, 8'hC0, 8'h02, 16'h00C0};
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 6; i = i + 1) begin
			reg_write(`AAU_A_CTRL, {5'h08, row[i][47:45]});
			repeat (6) @(posedge clk);
			reg_read(`AAU_A_CNT, 8'h00);
			reg_write(`AAU_A_SHIFT, {5'h00, row[i][44:42]});
			conv(row[i][41:32], 1'b1);
			conv(row[i][41:32], 1'b1);
			cmp_val("threshold", row[i][15:0], thr);
			reg_read(`AAU_A_FLTL, row[i][31:24]);
			reg_read(`AAU_A_CNT, row[i][23:16]);
		end
		reg_write(`AAU_A_RPT, 8'h03);
		reg_write(`AAU_A_CTRL, 8'h42);
		repeat (5) @(posedge clk);
		for (i = 0; i < 3; i = i + 1)
			conv(10'h004, i == 2);
		cmp_val("threshold", 16'h0006, thr);
		reg_write(`AAU_A_CTRL, 8'h01);
		reg_write(`AAU_A_ACCH, 8'hFF);
		reg_read(`AAU_A_ACCH, 8'hFF);
		reg_write(`AAU_A_ACCL, 8'hFE);
		reg_read(`AAU_A_ACCL, 8'hFE);
		reg_read(4'hF, 8'h00);
		conv(10'h2AB, 1'b1);
		reg_read(`AAU_A_STAT, 8'h01);
		reg_read(`AAU_A_ACCL, 8'hA9);
		conv(10'h001, 1'b1);
		reg_read(`AAU_A_PREVL, 8'hC0);
		reg_write(`AAU_A_CTRL, 8'h19);
		conv(10'h001, 1'b1);
		reg_read(`AAU_A_PREVL, 8'h55);
		reg_write(`AAU_A_CTRL, 8'h11);
		conv(10'h001, 1'b1);
		reg_read(`AAU_A_PREVL, 8'h01);
		reg_write(`AAU_A_TRIG, 8'h01);
		cmp <= 1'b1;
		for (n = 0; n < 8 && trig !== 1'b1; n = n + 1)
			@(negedge clk);
		cmp_val("trigger", 16'h0001, {15'h0000, trig});
		repeat (8) @(posedge clk);
		cmp <= 1'b0;
		reg_write(`AAU_A_CTRL, 8'h20);
		reg_write(`AAU_A_CTRL, 8'h60);
		repeat (2) @(posedge clk);
		reg_read(`AAU_A_STAT, 8'h03);
		// The slow clear ends one edge after the first read; wait it out.
		repeat (2) @(posedge clk);
		reg_read(`AAU_A_STAT, 8'h00);
		give_verdict;
	end
endmodule // test_aau_core

// ==== hdl/aau_core.v ====
// Purpose: Accumulate, average and low-pass unit behind a converter core.
// Assumes: Converter strobes are synchronous to i_ref_clk; comparator is not.
// Notes: Accumulator and previous-result bytes have no reset value.
//
// Function
// - On the RC oscillator, clearing the accumulator takes five clocks.
// - Three-bit shift field right-shifts the accumulator into the filtered result.
// - Average modes: result is sum divided by two to the shift value.
// - Low-pass mode: shift field sets recursion weight and hence cut-off.
// - Basic mode: no accumulation, threshold comparison still on each result.
// - Accumulate mode adds every finished conversion to the accumulator.
// - After accumulating, filtered result gets accumulator shifted right.
// - Accumulator always takes the right-justified result.
// - Each accumulated sample increments the sample counter until it reaches 255, where it holds.
// - Accumulate mode compares the accumulator after every sample.
// - Average mode accumulates, counts and updates filtered result.
// - Average mode compares only once counter reaches repeat target.
// - Source select one: previous low byte takes filtered low byte.
// - Source select zero: previous result takes conversion result.
// - Source select zero: previous result formatted like conversion result.
// - Accumulator readable and writable as high and low bytes.
// - Comparator trigger source starts conversion on comparator rising edge.
// - Overflow flag set when the sum exceeds sixteen bits.
// - Clear request zeroes accumulator, overflow flag and sample counter.
// - Hardware drops the clear request once clearing completes.
// - Repeat target holds the number of samples to accumulate.
`timescale 1ns/1ns
`include "aau_defs.vh"
module aau_core (
	// Clock and reset.
	input  wire        i_ref_clk,
	input  wire        i_rst_b,
	// Register port.
	input  wire [3:0]  i_addr,
	input  wire [7:0]  i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [7:0]  o_rdata,
	// Converter core side.
	input  wire        i_conv_start,
	input  wire        i_conv_done,
	input  wire [9:0]  i_conv_result,
	input  wire        i_cmp_out,
	output reg         o_conv_trigger,
	// Threshold comparison hand-off.
	output reg         o_thresh_check,
	output reg  [15:0] o_thresh_value
);

	reg  [2:0]  mode;
	reg         psis;
	reg         fmt;
	reg         rc_sel;
	reg  [2:0]  shift;
	reg  [3:0]  trig_src;
	reg  [7:0]  rpt;
	reg  [7:0]  cnt;
	reg         aov;
	reg         clr_busy;
	reg  [2:0]  clr_left;
	reg  [15:0] acc;
	reg  [15:0] filt;
	reg  [15:0] prev;
	reg  [15:0] res;
	reg         cmp_s1;
	reg         cmp_s2;
	reg         cmp_s3;

	reg  [16:0] next_sum;
	reg  [15:0] next_acc;
	reg  [15:0] next_filt;
	reg  [7:0]  next_cnt;
	reg         accum_on;
	reg  [15:0] res_fmt;
	reg  [7:0]  next_rdata;

	wire [15:0] res_right;
	wire        clr_done;
	wire        wr_ctrl;

	assign res_right = {6'h00, i_conv_result};
	assign clr_done  = clr_busy && (clr_left == `AAU_CLR_FAST);
	assign wr_ctrl   = i_wr && (i_addr == `AAU_A_CTRL);

	// Result justification, shared by the result and previous-result bytes.
	always @* begin
		if (fmt) begin
			res_fmt = res_right;
		end else begin
			res_fmt = {i_conv_result, 6'h00};
		end
	end

	// Datapath for one finished conversion; the accumulator base is zero in the
	// final clear cycle so a sample landing there is kept rather than lost.
	always @* begin
		accum_on  = (mode != `AAU_MD_BASIC);
		next_sum  = {1'b0, acc};
		next_cnt  = cnt;
		if (clr_done) begin
			next_sum = 17'h00000;
			next_cnt = `AAU_RST_CNT;
		end
		if (mode == `AAU_MD_LPF) begin
			next_sum = next_sum - {1'b0, (next_sum[15:0] >> shift)};
		end
		next_sum  = next_sum + {1'b0, res_right};
		next_acc  = next_sum[15:0];
		next_filt = next_acc >> shift;
		if (cnt != 8'hFF) begin
			next_cnt = next_cnt + 8'h01;
		end
	end

	// Comparator pin synchroniser and rising-edge trigger.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cmp_s1         <= 1'b0;
			cmp_s2         <= 1'b0;
			cmp_s3         <= 1'b0;
			o_conv_trigger <= 1'b0;
		end else begin
			cmp_s1         <= i_cmp_out;
			cmp_s2         <= cmp_s1;
			cmp_s3         <= cmp_s2;
			o_conv_trigger <= (trig_src == `AAU_TRIG_CMP) && cmp_s2 && !cmp_s3;
		end
	end

	// Software configuration and the clear sequencer.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mode     <= `AAU_MD_BASIC;
			psis     <= 1'b0;
			fmt      <= 1'b0;
			rc_sel   <= 1'b0;
			shift    <= `AAU_RST_SHIFT;
			trig_src <= `AAU_RST_TRIG;
			rpt      <= `AAU_RST_RPT;
			clr_busy <= 1'b0;
			clr_left <= 3'h0;
		end else begin
			if (wr_ctrl) begin
				mode   <= i_wdata[`AAU_B_MODE_HI:`AAU_B_MODE_LO];
				psis   <= i_wdata[`AAU_B_PSIS];
				fmt    <= i_wdata[`AAU_B_FM];
				rc_sel <= i_wdata[`AAU_B_RCSEL];
			end
			if (i_wr && (i_addr == `AAU_A_SHIFT)) begin
				shift <= i_wdata[2:0];
			end
			if (i_wr && (i_addr == `AAU_A_TRIG)) begin
				trig_src <= i_wdata[3:0];
			end
			if (i_wr && (i_addr == `AAU_A_RPT)) begin
				rpt <= i_wdata;
			end
			if (clr_done) begin
				clr_busy <= 1'b0;
			end else if (clr_busy) begin
				clr_left <= clr_left - 3'h1;
			end else if (wr_ctrl && i_wdata[`AAU_B_ACLR]) begin
				clr_busy <= 1'b1;
				// The duration follows the source selected before this write.
				clr_left <= rc_sel ? `AAU_CLR_RC_CYC : `AAU_CLR_FAST;
			end
		end
	end

	// Counter and overflow flag; a sample in the final clear cycle is counted from zero.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt <= `AAU_RST_CNT;
			aov <= 1'b0;
		end else begin
			if (i_conv_done && accum_on) begin
				cnt <= next_cnt;
				if (next_sum[16]) begin
					aov <= 1'b1;
				end else if (clr_done) begin
					aov <= 1'b0;
				end
			end else if (clr_done) begin
				cnt <= `AAU_RST_CNT;
				aov <= 1'b0;
			end
		end
	end

	// Accumulator has no reset so software sees an unknown value until loaded.
	always @(posedge i_ref_clk) begin
		if (i_conv_done && accum_on) begin
			acc <= next_acc;
		end else if (clr_done) begin
			acc <= 16'h0000;
		end else if (i_wr && (i_addr == `AAU_A_ACCL)) begin
			acc[7:0] <= i_wdata;
		end else if (i_wr && (i_addr == `AAU_A_ACCH)) begin
			acc[15:8] <= i_wdata;
		end
	end

	// Previous result is caught at conversion start and has no reset either.
	always @(posedge i_ref_clk) begin
		if (i_conv_start) begin
			if (psis) begin
				prev <= filt;
			end else begin
				prev <= res;
			end
		end
	end

	// Filtered and conversion result registers.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			filt <= 16'h0000;
			res  <= 16'h0000;
		end else begin
			if (i_conv_done) begin
				res <= res_fmt;
			end
			if (i_conv_done && accum_on) begin
				filt <= next_filt;
			end else if (clr_done) begin
				filt <= 16'h0000;
			end
		end
	end

	// Threshold hand-off: the comparison itself lives in the converter core.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_thresh_check <= 1'b0;
			o_thresh_value <= 16'h0000;
		end else begin
			o_thresh_check <= 1'b0;
			if (i_conv_done) begin
				case (mode)
					`AAU_MD_BASIC: begin
						o_thresh_check <= 1'b1;
						o_thresh_value <= res_right;
					end
					`AAU_MD_ACCUM: begin
						o_thresh_check <= 1'b1;
						o_thresh_value <= next_acc;
					end
					`AAU_MD_AVG,
					`AAU_MD_BURST: begin
						// The value only moves with a check so the converter never sees a
						// partial average between checks.
						if (next_cnt >= rpt) begin
							o_thresh_check <= 1'b1;
							o_thresh_value <= next_filt;
						end
					end
					`AAU_MD_LPF: begin
						o_thresh_check <= 1'b1;
						o_thresh_value <= next_filt;
					end
					default: begin
						o_thresh_check <= 1'b0;
					end
				endcase
			end
		end
	end

	// Read multiplexer; unmapped indexes read as zero.
	always @* begin
		case (i_addr)
			`AAU_A_CTRL:  next_rdata = {1'b0, clr_busy, rc_sel, fmt, psis, mode};
			`AAU_A_SHIFT: next_rdata = {5'h00, shift};
			`AAU_A_TRIG:  next_rdata = {4'h0, trig_src};
			`AAU_A_RPT:   next_rdata = rpt;
			`AAU_A_CNT:   next_rdata = cnt;
			`AAU_A_STAT:  next_rdata = {6'h00, clr_busy, aov};
			`AAU_A_ACCL:  next_rdata = acc[7:0];
			`AAU_A_ACCH:  next_rdata = acc[15:8];
			`AAU_A_FLTL:  next_rdata = filt[7:0];
			`AAU_A_FLTH:  next_rdata = filt[15:8];
			`AAU_A_PREVL: next_rdata = prev[7:0];
			`AAU_A_PREVH: next_rdata = prev[15:8];
			`AAU_A_RESL:  next_rdata = res[7:0];
			`AAU_A_RESH:  next_rdata = res[15:8];
			default:      next_rdata = 8'h00;
		endcase
	end

	// Read data stand only in the cycle after the read strobe.
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= 8'h00;
		end
	end

endmodule // aau_core

// ==== hdl/aau_defs.vh ====
// Purpose: Constants of the accumulate and average unit.
// Assumes: Eight-bit register bus with a four-bit register index.
// Notes: Offsets are register indexes on the plain register port.
`ifndef AAU_DEFS_VH
`define AAU_DEFS_VH
// Register indexes.
`define AAU_A_CTRL   4'h0
`define AAU_A_SHIFT  4'h1
`define AAU_A_TRIG   4'h2
`define AAU_A_RPT    4'h3
`define AAU_A_CNT    4'h4
`define AAU_A_STAT   4'h5
`define AAU_A_ACCL   4'h6
`define AAU_A_ACCH   4'h7
`define AAU_A_FLTL   4'h8
`define AAU_A_FLTH   4'h9
`define AAU_A_PREVL  4'hA
`define AAU_A_PREVH  4'hB
`define AAU_A_RESL   4'hC
`define AAU_A_RESH   4'hD
// Control register fields.
`define AAU_B_MODE_HI 2
`define AAU_B_MODE_LO 0
`define AAU_B_PSIS    3
`define AAU_B_FM      4
`define AAU_B_RCSEL   5
`define AAU_B_ACLR    6
// Status register fields.
`define AAU_B_AOV     0
`define AAU_B_BUSY    1
// Computation modes.
`define AAU_MD_BASIC  3'h0
`define AAU_MD_ACCUM  3'h1
`define AAU_MD_AVG    3'h2
`define AAU_MD_BURST  3'h3
`define AAU_MD_LPF    3'h4
// Trigger source code that selects the comparator output.
`define AAU_TRIG_CMP  4'h1
// Clear duration in converter clocks, on the RC oscillator and off it.
`define AAU_CLR_RC_CYC 3'h5
`define AAU_CLR_FAST   3'h1
// Reset values.
`define AAU_RST_CTRL  8'h00
`define AAU_RST_SHIFT 3'h0
`define AAU_RST_TRIG  4'h0
`define AAU_RST_RPT   8'h00
`define AAU_RST_CNT   8'h00
`endif
